// >>> rtl/rmu_pkg.sv
package rmu_pkg;
  // Register byte offsets
  localparam logic [7:0] RMU_OFS_DATA  = 8'h00;
  localparam logic [7:0] RMU_OFS_IER   = 8'h04;
  localparam logic [7:0] RMU_OFS_FCR   = 8'h08;
  localparam logic [7:0] RMU_OFS_LCR   = 8'h0C;
  localparam logic [7:0] RMU_OFS_MCR   = 8'h10;
  localparam logic [7:0] RMU_OFS_MSR   = 8'h14;
  localparam logic [7:0] RMU_OFS_FSR   = 8'h18;
  localparam logic [7:0] RMU_OFS_ISR   = 8'h1C;
  localparam logic [7:0] RMU_OFS_TOR   = 8'h20;
  localparam logic [7:0] RMU_OFS_BAUD  = 8'h24;
  localparam logic [7:0] RMU_OFS_IRCR  = 8'h28;
  localparam logic [7:0] RMU_OFS_ALT   = 8'h2C;
  localparam logic [7:0] RMU_OFS_FUN   = 8'h30;
  // Reset values
  localparam logic [31:0] RMU_RST_FCR  = 32'h0000_0101;
  localparam logic [31:0] RMU_RST_MCR  = 32'h0000_0200;
  localparam logic [31:0] RMU_RST_MSR  = 32'h0000_0110;
  localparam logic [31:0] RMU_RST_FSR  = 32'h1040_4000;
  localparam logic [31:0] RMU_RST_ISR  = 32'h0000_0002;
  localparam logic [31:0] RMU_RST_BAUD = 32'h0F00_0000;
  localparam logic [31:0] RMU_RST_IRCR = 32'h0000_0040;
  // Field positions
  localparam int RMU_FCR_RXDIS   = 8;
  localparam int RMU_LCR_PBE     = 3;
  localparam int RMU_LCR_EPE     = 4;
  localparam int RMU_LCR_SPE     = 5;
  localparam int RMU_MCR_REQ     = 1;
  localparam int RMU_MCR_POL     = 9;
  localparam int RMU_MCR_PINST   = 13;
  localparam int RMU_ALT_NMM     = 8;
  localparam int RMU_ALT_AAD     = 9;
  localparam int RMU_ALT_AUD     = 10;
  localparam int RMU_ALT_MATCH   = 24;
  localparam int RMU_TOR_DLY     = 8;
  localparam int RMU_IER_RDA     = 0;
  localparam int RMU_FSR_RXEMPTY = 14;
  localparam int RMU_FSR_TXFULL  = 23;
  localparam int RMU_FSR_TXEMPTY = 22;
  localparam int RMU_FSR_TEFLAG  = 28;
  localparam logic [1:0] RMU_FUN_RS485 = 2'h3;
  // Baud divisor field, 16 ticks of (divisor+1) clocks per bit
  localparam int RMU_BAUD_W      = 16;
  localparam logic [3:0] RMU_OVS_LAST = 4'hF;
  localparam int RMU_FIFO_DEPTH  = 8;
  localparam int RMU_CHAR_W      = 9;
endpackage : rmu_pkg

// >>> rtl/rmu_fifo.sv
`timescale 1ns/1ps
module rmu_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  // Status
  output logic                  full,
  output logic                  empty
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } rmu_fifo_s;
  rmu_fifo_s             st;
  rmu_fifo_s             next_st;
  logic      [WIDTH-1:0] mem [DEPTH];
  logic                  push;
  logic                  pop;

  assign full      = (st.cnt == (AW+1)'(DEPTH));
  assign empty     = (st.cnt == '0);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;
  assign out_data  = mem[st.rp];

  always_comb begin
    next_st = st;
    if (push) next_st.wp = st.wp + 1'b1;
    if (pop) next_st.rp = st.rp + 1'b1;
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st <= '0;
    else st <= next_st;
  end

  // Storage carries no reset so it can map onto RAM
  always_ff @(posedge pclk) begin
    if (push) mem[st.wp] <= in_data;
  end
endmodule : rmu_fifo

// >>> rtl/rmu_uart.sv
// Our own choice: the APB register port.
`timescale 1ns/1ps
module rmu_uart
  import rmu_pkg::*;
(
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial line
  input  wire logic        rx_pin,
  output logic             tx_pin,
  output logic             direction_pin,
  // Interrupt of receive-data-available
  output logic             rx_irq
);
  import rmu_pkg::*;

  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_HOLD} rmu_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_SHIFT, RX_STOP} rmu_rx_e;

  typedef struct packed {
    logic [31:0] ier;
    logic [31:0] fcr;
    logic [31:0] lcr;
    logic [31:0] mcr;
    logic [31:0] tor;
    logic [31:0] baud;
    logic [31:0] alt;
    logic [1:0]  fun;
    logic        rdata_valid;
    logic [31:0] rdata;
    rmu_tx_e     txs;
    logic [15:0] tx_div;
    logic [3:0]  tx_ovs;
    logic [3:0]  tx_bit;
    logic [10:0] tx_sh;
    logic [7:0]  tx_dly;
    logic        tx_pin;
    rmu_rx_e     rxs;
    logic [15:0] rx_div;
    logic [3:0]  rx_ovs;
    logic [3:0]  rx_bit;
    logic [8:0]  rx_sh;
    logic        aad_match;
    logic        addr_ev;
    logic        rx_s1;
    logic        rx_s2;
  } rmu_s;

  rmu_s        st;
  rmu_s        next_st;
  logic        wr_acc;
  logic        rd_acc;
  logic        fifo_pop;
  logic        tx_in_valid;
  logic        tx_in_ready;
  logic        tx_out_valid;
  logic [8:0]  tx_out_data;
  logic        tx_pop;
  logic        rx_in_valid;
  logic        rx_done;
  logic        rx_in_ready;
  logic        rx_out_valid;
  logic [8:0]  rx_out_data;
  logic        rx_empty;
  logic        rx_full;
  logic        tx_empty;
  logic        tx_full;
  logic        rs485;
  logic        dir_int;
  logic        ninth;
  logic        store;
  logic        is_addr;
  logic [8:0]  rx_char;
  logic [31:0] rd_word;

  assign rs485  = (st.fun == RMU_FUN_RS485);
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign fifo_pop = rd_acc && (paddr == RMU_OFS_DATA);
  assign tx_in_valid = wr_acc && (paddr == RMU_OFS_DATA);

  // Stick parity carries the ninth bit; other parity is computed
  always_comb begin
    if (st.lcr[RMU_LCR_SPE])
      ninth = !st.lcr[RMU_LCR_EPE];
    else
      ninth = (^pwdata[7:0]) ^ !st.lcr[RMU_LCR_EPE];
  end

  rmu_fifo #(.WIDTH(RMU_CHAR_W), .DEPTH(RMU_FIFO_DEPTH)) u_txf (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (tx_in_valid),
    .in_ready  (tx_in_ready),
    .in_data   ({ninth, pwdata[7:0]}),
    .out_valid (tx_out_valid),
    .out_ready (tx_pop),
    .out_data  (tx_out_data),
    .full      (tx_full),
    .empty     (tx_empty)
  );

  rmu_fifo #(.WIDTH(RMU_CHAR_W), .DEPTH(RMU_FIFO_DEPTH)) u_rxf (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (rx_in_valid),
    .in_ready  (rx_in_ready),
    .in_data   (rx_char),
    .out_valid (rx_out_valid),
    .out_ready (fifo_pop),
    .out_data  (rx_out_data),
    .full      (rx_full),
    .empty     (rx_empty)
  );

  assign tx_pop = (st.txs != TX_SHIFT) && tx_out_valid;
  assign rx_char = st.rx_sh;
  assign is_addr = st.rx_sh[8];

  // Receive filtering decides whether a finished character is stored
  always_comb begin
    store = 1'b1;
    if (rs485 && st.alt[RMU_ALT_AAD]) begin
      if (is_addr)
        store = (st.rx_sh[7:0] == st.alt[RMU_ALT_MATCH +: 8]);
      else
        store = st.aad_match;
    end else if (rs485 && st.alt[RMU_ALT_NMM]) begin
      store = is_addr || !st.fcr[RMU_FCR_RXDIS];
    end else if (st.fcr[RMU_FCR_RXDIS]) begin
      store = 1'b0;
    end
  end

  assign rx_done     = (st.rxs == RX_STOP) && st.rx_ovs == RMU_OVS_LAST &&
                       st.rx_div == '0 && st.rx_s2;
  assign rx_in_valid = rx_done && store;

  // Auto direction holds high through shift and turnaround
  assign dir_int = (rs485 && st.alt[RMU_ALT_AUD]) ?
                   (st.txs != TX_IDLE) :
                   st.mcr[RMU_MCR_REQ];
  assign direction_pin = dir_int ^ st.mcr[RMU_MCR_POL];
  assign tx_pin = st.tx_pin;
  assign rx_irq = st.ier[RMU_IER_RDA] &&
                  (!rx_empty || st.addr_ev);
  assign prdata = st.rdata;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (paddr == RMU_OFS_DATA) rd_word = {23'h0, rx_out_data};
    else if (paddr == RMU_OFS_IER) rd_word = st.ier;
    else if (paddr == RMU_OFS_FCR) rd_word = st.fcr;
    else if (paddr == RMU_OFS_LCR) rd_word = st.lcr;
    else if (paddr == RMU_OFS_MCR) begin
      rd_word = st.mcr;
      rd_word[RMU_MCR_PINST] = direction_pin;
    end
    else if (paddr == RMU_OFS_MSR) rd_word = RMU_RST_MSR;
    else if (paddr == RMU_OFS_FSR) begin
      rd_word = RMU_RST_FSR;
      rd_word[RMU_FSR_RXEMPTY] = rx_empty;
      rd_word[RMU_FSR_TXEMPTY] = tx_empty;
      rd_word[RMU_FSR_TXFULL]  = tx_full;
      rd_word[RMU_FSR_TEFLAG]  = tx_empty && st.txs == TX_IDLE;
    end
    else if (paddr == RMU_OFS_ISR) begin
      rd_word = RMU_RST_ISR;
      rd_word[RMU_IER_RDA] = rx_irq;
    end
    else if (paddr == RMU_OFS_TOR) rd_word = st.tor;
    else if (paddr == RMU_OFS_BAUD) rd_word = st.baud;
    else if (paddr == RMU_OFS_IRCR) rd_word = RMU_RST_IRCR;
    else if (paddr == RMU_OFS_ALT) rd_word = st.alt;
    else if (paddr == RMU_OFS_FUN) rd_word = {30'h0, st.fun};
  end

  always_comb begin
    next_st = st;
    next_st.rx_s1 = rx_pin;
    next_st.rx_s2 = st.rx_s1;
    // Read data is registered during the setup cycle
    if (psel && !penable && !pwrite) next_st.rdata = rd_word;
    next_st.addr_ev = st.addr_ev && !fifo_pop;
    if (wr_acc) begin
      if (paddr == RMU_OFS_IER) next_st.ier = pwdata;
      else if (paddr == RMU_OFS_FCR) next_st.fcr = pwdata;
      else if (paddr == RMU_OFS_LCR) next_st.lcr = pwdata;
      else if (paddr == RMU_OFS_MCR) next_st.mcr = pwdata;
      else if (paddr == RMU_OFS_TOR) next_st.tor = pwdata;
      else if (paddr == RMU_OFS_BAUD) next_st.baud = pwdata;
      else if (paddr == RMU_OFS_ALT) next_st.alt = pwdata;
      else if (paddr == RMU_OFS_FUN) next_st.fun = pwdata[1:0];
    end
    // Transmitter: 16 clocks of (divisor+1) per bit
    if (st.txs == TX_IDLE || st.txs == TX_HOLD) begin
      if (tx_out_valid) begin
        next_st.txs    = TX_SHIFT;
        next_st.tx_sh  = st.lcr[RMU_LCR_PBE] ?
                         {1'b1, tx_out_data, 1'b0} :
                         {2'b11, tx_out_data[7:0], 1'b0};
        next_st.tx_bit = st.lcr[RMU_LCR_PBE] ? 4'd10 : 4'd9;
        next_st.tx_div = '0;
        next_st.tx_ovs = '0;
        next_st.tx_pin = 1'b0;
      end else if (st.txs == TX_HOLD) begin
        if (st.tx_div == st.baud[RMU_BAUD_W-1:0]) begin
          next_st.tx_div = '0;
          next_st.tx_ovs = st.tx_ovs + 4'd1;
          if (st.tx_ovs == RMU_OVS_LAST) begin
            if (st.tx_dly == '0) next_st.txs = TX_IDLE;
            else next_st.tx_dly = st.tx_dly - 8'd1;
          end
        end else next_st.tx_div = st.tx_div + 16'd1;
      end
    end else if (st.tx_div == st.baud[RMU_BAUD_W-1:0]) begin
      next_st.tx_div = '0;
      next_st.tx_ovs = st.tx_ovs + 4'd1;
      if (st.tx_ovs == RMU_OVS_LAST) begin
        if (st.tx_bit == '0) begin
          // A zero delay releases the line right at the stop bit's end
          if (st.tor[RMU_TOR_DLY +: 8] == 8'h00) begin
            next_st.txs = TX_IDLE;
          end else begin
            next_st.txs    = TX_HOLD;
            next_st.tx_dly = st.tor[RMU_TOR_DLY +: 8] - 8'h01;
          end
        end else begin
          next_st.tx_pin = st.tx_sh[1];
          next_st.tx_sh  = {1'b1, st.tx_sh[10:1]};
          next_st.tx_bit = st.tx_bit - 4'd1;
        end
      end
    end else next_st.tx_div = st.tx_div + 16'd1;
    if (st.txs == TX_HOLD && st.tx_ovs == RMU_OVS_LAST &&
        st.tx_div == st.baud[RMU_BAUD_W-1:0] && st.tx_dly == '0 &&
        !tx_out_valid)
      next_st.tx_pin = 1'b1;
    // Receiver samples mid-bit
    if (st.rxs == RX_IDLE) begin
      if (!st.rx_s2) begin
        next_st.rxs    = RX_SHIFT;
        next_st.rx_div = '0;
        next_st.rx_ovs = 4'd8;
        next_st.rx_bit = st.lcr[RMU_LCR_PBE] ? 4'd10 : 4'd9;
      end
    end else if (st.rx_div == st.baud[RMU_BAUD_W-1:0]) begin
      next_st.rx_div = '0;
      next_st.rx_ovs = st.rx_ovs + 4'd1;
      if (st.rx_ovs == RMU_OVS_LAST) begin
        if (st.rxs == RX_STOP) next_st.rxs = RX_IDLE;
        else begin
          if (st.rx_bit != (st.lcr[RMU_LCR_PBE] ? 4'd10 : 4'd9))
            next_st.rx_sh = st.lcr[RMU_LCR_PBE] ?
                            {st.rx_s2, st.rx_sh[8:1]} :
                            {1'b0, st.rx_s2, st.rx_sh[7:1]};
          next_st.rx_bit = st.rx_bit - 4'd1;
          if (st.rx_bit == 4'd1) next_st.rxs = RX_STOP;
        end
      end
    end else next_st.rx_div = st.rx_div + 16'd1;
    // Every finished RS-485 address updates the match in auto address mode, stored or not; in multidrop mode it clears RXDIS instead
    if (rx_done && rs485 && is_addr) begin
      if (rx_in_valid) next_st.addr_ev = 1'b1;
      if (st.alt[RMU_ALT_AAD])
        next_st.aad_match = store;
      else if (st.alt[RMU_ALT_NMM])
        next_st.fcr[RMU_FCR_RXDIS] = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st        <= '0;
      st.fcr    <= RMU_RST_FCR;
      st.mcr    <= RMU_RST_MCR;
      st.baud   <= RMU_RST_BAUD;
      st.txs    <= TX_IDLE;
      st.rxs    <= RX_IDLE;
      st.tx_pin <= 1'b1;
      st.rx_s1  <= 1'b1;
      st.rx_s2  <= 1'b1;
    end else st <= next_st;
  end

  a_dir_polarity: assert property (@(posedge pclk) disable iff (!presetn)
    direction_pin == (dir_int ^ st.mcr[RMU_MCR_POL]))
    else $error("direction pin polarity wrong");
  a_dir_software: assert property (@(posedge pclk) disable iff (!presetn)
    !(rs485 && st.alt[RMU_ALT_AUD]) |->
    direction_pin == (st.mcr[RMU_MCR_REQ] ^ st.mcr[RMU_MCR_POL]))
    else $error("software direction not followed");
  a_dir_auto_tx: assert property (@(posedge pclk) disable iff (!presetn)
    (rs485 && st.alt[RMU_ALT_AUD] && st.txs == TX_SHIFT) |->
    direction_pin != st.mcr[RMU_MCR_POL])
    else $error("direction not driven during transmit");
  a_rxdis_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_in_valid && rs485 && is_addr && st.alt[RMU_ALT_NMM] &&
     !st.alt[RMU_ALT_AAD]) |=> !st.fcr[RMU_FCR_RXDIS])
    else $error("receiver disable not cleared");
  a_drop_data: assert property (@(posedge pclk) disable iff (!presetn)
    (rs485 && st.alt[RMU_ALT_NMM] && !st.alt[RMU_ALT_AAD] &&
     st.fcr[RMU_FCR_RXDIS] && !is_addr) |-> !rx_in_valid)
    else $error("data stored while receiver disabled");
  a_aad_match: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_in_valid && rs485 && st.alt[RMU_ALT_AAD] && is_addr) |->
    st.rx_sh[7:0] == st.alt[RMU_ALT_MATCH +: 8])
    else $error("non-matching address stored");
  a_irq_addr: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_in_valid && rs485 && is_addr && st.ier[RMU_IER_RDA]) |=>
    rx_irq)
    else $error("address did not raise interrupt");
  a_stick_ninth: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_in_valid && tx_in_ready && st.lcr[RMU_LCR_SPE]) |->
    ninth == !st.lcr[RMU_LCR_EPE])
    else $error("stick ninth bit wrong");
endmodule : rmu_uart

// >>> sim/rmu_node.sv
`timescale 1ns/1ps
module rmu_node #(
  parameter int BIT_CLKS = 16
) (
  // Clock
  input  wire logic pclk,
  // Line
  output logic      rx_pin,
  input  wire logic tx_pin
);
  logic [8:0] got;
  int         n_got;
  logic [9:0] sh;

  // Biased line rests high between frames
  initial begin
    rx_pin = 1'b1;
    got    = '0;
    n_got  = 0;
  end

  // Start, eight data bits LSB first, ninth bit, one stop
  task automatic send(input logic [8:0] ch);
    logic [10:0] f;
    f = {1'b1, ch, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge pclk);
      rx_pin <= f[i];
      repeat (BIT_CLKS - 1) @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
  endtask : send

  // Samples mid-bit; ninth bit lands in got[8]
  always begin
    @(negedge tx_pin);
    repeat (BIT_CLKS / 2) @(posedge pclk);
    for (int i = 0; i < 10; i++) begin
      repeat (BIT_CLKS) @(posedge pclk);
      sh[i] = tx_pin;
    end
    got = sh[8:0];
    n_got++;
  end
endmodule : rmu_node

// >>> sim/rmu_uart_tb.sv
`timescale 1ns/1ps
module rmu_uart_tb;
  import rmu_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, rx_pin, tx_pin, direction_pin, rx_irq;
  int          n_mismatch, checked, i, n;
  logic [7:0]  ofs [12] = '{RMU_OFS_IER, RMU_OFS_FCR, RMU_OFS_LCR,
    RMU_OFS_MCR, RMU_OFS_MSR, RMU_OFS_FSR, RMU_OFS_ISR, RMU_OFS_TOR,
    RMU_OFS_BAUD, RMU_OFS_IRCR, RMU_OFS_ALT, RMU_OFS_FUN};
  // Modem control reads the direction pin back, high out of reset
  logic [31:0] rst [12] = '{32'h0, RMU_RST_FCR, 32'h0,
    RMU_RST_MCR | 32'h0000_2000, RMU_RST_MSR, RMU_RST_FSR, RMU_RST_ISR,
    32'h0, RMU_RST_BAUD, RMU_RST_IRCR, 32'h0, 32'h0};

  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  rmu_uart DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .direction_pin(direction_pin), .rx_irq(rx_irq));

  rmu_node #(.BIT_CLKS(16)) far_end (
    .pclk(pclk), .rx_pin(rx_pin), .tx_pin(tx_pin));

  task automatic give_verdict();
    if (n_mismatch == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Request held from setup until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    chk(pslverr, 1'b0);
    psel    <= 1'b0;
    penable <= 1'b0;
    // Return mid-cycle so callers see outputs settled after the access
    @(negedge pclk);
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  task automatic wait_tx(input int k);
    n = 0;
    while (far_end.n_got < k && n < 1000) begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_tx

  // Whole run needs well under 10000 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    n_mismatch = 0;
    checked    = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 12; i++) rdchk(ofs[i], rst[i]);
    rdchk(8'h3C, 32'h0);
    chk(direction_pin, 1'b1);
    apb(1'b1, RMU_OFS_FUN, 32'h3);
    rdchk(RMU_OFS_FUN, 32'h3);
    apb(1'b1, RMU_OFS_BAUD, 32'h0);
    apb(1'b1, RMU_OFS_LCR, 32'h38);
    apb(1'b1, RMU_OFS_IER, 32'h1);
    for (i = 0; i < 4; i++) begin
      apb(1'b1, RMU_OFS_MCR, {22'h0, i[1], 7'h0, i[0], 1'b0});
      chk(direction_pin, i[0] ^ i[1]);
      rdchk(RMU_OFS_MCR, {18'h0, i[0] ^ i[1], 3'h0, i[1], 7'h0, i[0],
                          1'b0});
    end
    apb(1'b1, RMU_OFS_MCR, 32'h0);
    apb(1'b1, RMU_OFS_DATA, 32'hA5);
    wait_tx(1);
    chk(far_end.got, 9'h0A5);
    // Auto direction, two extra bit periods of turnaround
    apb(1'b1, RMU_OFS_TOR, 32'h200);
    apb(1'b1, RMU_OFS_LCR, 32'h28);
    apb(1'b1, RMU_OFS_ALT, 32'h400);
    apb(1'b1, RMU_OFS_DATA, 32'h3C);
    n = 0;
    while (tx_pin === 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk(direction_pin, 1'b1);
    n = 0;
    while (direction_pin === 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    // Eleven frame bits plus two delay bits, a few clocks of slack
    chk(n >= 206 && n <= 210, 1'b1);
    wait_tx(2);
    chk(far_end.got, 9'h13C);
    // Multidrop, receiver on: fill the receive FIFO past its depth
    apb(1'b1, RMU_OFS_ALT, 32'h100);
    apb(1'b1, RMU_OFS_FCR, 32'h1);
    for (i = 0; i < 9; i++) far_end.send(9'h10 + i[8:0]);
    for (i = 0; i < 8; i++) rdchk(RMU_OFS_DATA, 32'h10 + i);
    apb(1'b0, RMU_OFS_FSR, 32'h0);
    chk(rd[RMU_FSR_RXEMPTY], 1'b1);
    // Multidrop, receiver off until an address
    apb(1'b1, RMU_OFS_FCR, 32'h101);
    far_end.send(9'h011);
    apb(1'b0, RMU_OFS_FSR, 32'h0);
    chk(rd[RMU_FSR_RXEMPTY], 1'b1);
    apb(1'b1, RMU_OFS_IER, 32'h0);
    far_end.send(9'h122);
    chk(rx_irq, 1'b0);
    apb(1'b1, RMU_OFS_IER, 32'h1);
    repeat (2) @(posedge pclk);
    chk(rx_irq, 1'b1);
    apb(1'b0, RMU_OFS_FCR, 32'h0);
    chk(rd[RMU_FCR_RXDIS], 1'b0);
    far_end.send(9'h033);
    rdchk(RMU_OFS_DATA, 32'h122);
    rdchk(RMU_OFS_DATA, 32'h033);
    // Auto address with match value 0x5A
    apb(1'b1, RMU_OFS_ALT, 32'h5A00_0200);
    far_end.send(9'h144);
    far_end.send(9'h001);
    far_end.send(9'h15A);
    far_end.send(9'h002);
    far_end.send(9'h144);
    far_end.send(9'h003);
    rdchk(RMU_OFS_DATA, 32'h15A);
    rdchk(RMU_OFS_DATA, 32'h002);
    apb(1'b0, RMU_OFS_FSR, 32'h0);
    chk(rd[RMU_FSR_RXEMPTY], 1'b1);
    give_verdict();
  end
endmodule : rmu_uart_tb
